/* File: core/temp_sensor_alarm_serial.sv */
// Operation
// - Only exactly 24 clocks make valid frame
// - Ignore clock and data while deselected
// - Write bits sampled on rising clock
// - Read bits shifted out on falling clock
// - Eight command clocks, then sixteen data clocks
// - Command and data travel MSB first
// - Drive from falling edge eight until deselect
// - Convert continuously, refresh twice per second
// - Config bits: queue, polarities, interrupt, shutdown
// - Reserved config bits ignore writes
// - Interrupt mode: fault latches warning output
// - Temperature read clears interrupt-mode warning
// - Re-assert only at matching hysteresis point
// - Comparator mode asserts outside limits
// - Comparator mode releases past hysteresis point
// - Comparator mode unaffected by reads
// - Overheat output is comparator with hysteresis
// - Reads never clear overheat output
// - Fault queue needs four consecutive faults
// - Shutdown stops conversion, keeps registers
// - Command bit 7 start, bit 6 read
// - Eleven command codes select registers
// - Temperature word: value bits 15..3, flags
// - Limits use top nine bits only
`timescale 1ns/1ps
module temp_sensor_alarm_serial
  import temp_alarm_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int QUEUE_LEN   = QUEUE_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        sel_n,
  input  wire logic        serial_data_io_i,
  output logic             serial_data_io_o,
  output logic             serial_data_io_oe,
  input  wire logic [12:0] conv_result,
  output logic             alert_o,
  output logic             alert_oe,
  output logic             overheat_out_o,
  output logic             overheat_out_oe
);

  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam int QW     = $clog2(QUEUE_LEN + 1);

  function automatic logic is_read_cmd(input logic [7:0] c);
    is_read_cmd = (c == CMD_RD_TEMP) || (c == CMD_RD_CFG) || (c == CMD_RD_HYST) ||
                  (c == CMD_RD_CRIT) || (c == CMD_RD_LOWER) || (c == CMD_RD_UPPER);
  endfunction

  // Limit in whole degrees to sixteenths, sign extended
  function automatic logic signed [14:0] to_fix(input logic [15:0] r);
    to_fix = {r[15], r[15], r[15:7], 4'h0};
  endfunction

  logic [15:0]  cfg_q;
  logic [15:0]  hyst_q;
  logic [15:0]  crit_q;
  logic [15:0]  lower_q;
  logic [15:0]  upper_q;
  logic [12:0]  temp_q;
  logic [2:0]   flags_q;
  logic [15:0]  temp_word_sh_q;
  logic [4:0]   link_cnt_q;
  logic [7:0]   cmd_q;
  logic [15:0]  wdata_q;
  logic         fresh_q;
  logic         seen_tog_q;
  logic         seen_ack_q;
  logic [15:0]  shift_q;
  logic [15:0]  rd_word;
  logic         frame_idle;
  logic         sel_s1_q;
  logic         sel_s2_q;
  logic         sel_s3_q;
  logic         commit;
  logic         frame_ok;
  logic         wr_frame;
  logic         temp_read;
  logic [CONV_W-1:0] conv_cnt_q;
  logic         tick;
  logic         shutdown;
  logic         int_mode;
  logic         queue_on;
  logic [QW-1:0] qneed;
  alert_state_t al_q;
  alert_state_t al_d;
  logic [QW-1:0] aq_q;
  logic [QW-1:0] aq_d;
  logic         alert_act;
  logic         ot_q;
  logic [QW-1:0] oq_q;
  logic signed [14:0] t_now;
  logic         t_hi;
  logic         t_lo;
  logic         t_over;
  logic         t_below_hh;
  logic         t_above_lh;
  logic         t_below_ch;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, runs on the master's clock

  assign frame_idle = sel_n | ~reset_n;

  always_ff @(posedge link_clk or posedge frame_idle) begin
    if (frame_idle) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Counter and data are not cleared on deselect: ref domain reads them after
  // sample on rising clock, MSB first
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_cnt_q <= 5'h00;
      cmd_q      <= 8'h00;
      wdata_q    <= 16'h0000;
      seen_tog_q <= 1'b0;
    end else if (!sel_n) begin
      if (fresh_q) begin
        seen_tog_q <= ~seen_tog_q;
        link_cnt_q <= 5'h01;
        cmd_q      <= {7'h00, serial_data_io_i};
      end else begin
        if (link_cnt_q != CNT_SAT_C) begin
          link_cnt_q <= link_cnt_q + 5'h01;
        end
        // first eight bits are command, then data
        if (link_cnt_q < CMD_DONE_C) begin
          cmd_q <= {cmd_q[6:0], serial_data_io_i};
        end else begin
          wdata_q <= {wdata_q[14:0], serial_data_io_i};
        end
      end
    end
  end

  always_comb begin
    case (cmd_q)
      CMD_RD_TEMP:  rd_word = temp_word_sh_q;
      CMD_RD_CFG:   rd_word = cfg_q;
      CMD_RD_HYST:  rd_word = hyst_q;
      CMD_RD_CRIT:  rd_word = crit_q;
      CMD_RD_LOWER: rd_word = lower_q;
      CMD_RD_UPPER: rd_word = upper_q;
      default:      rd_word = 16'h0000;
    endcase
  end

  // load at falling edge eight, hold drive until deselect
  always_ff @(negedge link_clk or posedge frame_idle) begin
    if (frame_idle) begin
      shift_q           <= 16'h0000;
      serial_data_io_oe <= 1'b0;
    end else if (!fresh_q && link_cnt_q == CMD_DONE_C && is_read_cmd(cmd_q)) begin
      shift_q           <= rd_word;
      serial_data_io_oe <= 1'b1;
    end else if (serial_data_io_oe) begin
      shift_q <= {shift_q[14:0], 1'b0};
    end
  end

  assign serial_data_io_o = shift_q[15];

  ////////////////////////////////////////////////////////////////////////////
  // Frame end, seen in the ref domain

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
    end else begin
      sel_s1_q <= sel_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
    end
  end

  // a frame without clocks leaves the old count, so it must not commit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_ack_q <= 1'b0;
    end else if (commit) begin
      seen_ack_q <= seen_tog_q;
    end
  end

  // Link words are quiet once the clock has stopped, so read them directly
  // only a 24-clock frame commits, start bit required
  assign commit    = sel_s2_q & ~sel_s3_q;
  assign frame_ok  = commit && link_cnt_q == FRAME_LEN_C && cmd_q[CMD_START_BIT] &&
                     seen_tog_q != seen_ack_q;
  assign wr_frame  = frame_ok && !cmd_q[CMD_DIR_BIT];
  assign temp_read = frame_ok && cmd_q == CMD_RD_TEMP;

  assign shutdown = cfg_q[CFG_SHUTDOWN];
  assign int_mode = cfg_q[CFG_INT_MODE];
  assign queue_on = cfg_q[CFG_QUEUE_BIT];

  // control bits, reserved bits masked, limits top bits only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q   <= CFG_RESET;
      hyst_q  <= HYST_RESET;
      crit_q  <= CRIT_RESET;
      lower_q <= LOWER_RESET;
      upper_q <= UPPER_RESET;
    end else if (wr_frame) begin
      case (cmd_q)
        CMD_WR_CFG:   cfg_q   <= wdata_q & CFG_WRITE_MASK;
        CMD_WR_HYST:  hyst_q  <= wdata_q & LIMIT_MASK;
        CMD_WR_CRIT:  crit_q  <= wdata_q & LIMIT_MASK;
        CMD_WR_LOWER: lower_q <= wdata_q & LIMIT_MASK;
        CMD_WR_UPPER: upper_q <= wdata_q & LIMIT_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing

  // periodic refresh; an access restarts the conversion
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= '0;
    end else if (shutdown || frame_ok || tick) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  assign tick = !shutdown && conv_cnt_q == CONV_W'(CONV_CYCLES - 1);

  assign t_now      = {{2{conv_result[12]}}, conv_result};
  assign t_hi       = t_now > to_fix(upper_q);
  assign t_lo       = t_now < to_fix(lower_q);
  assign t_over     = t_now > to_fix(crit_q);
  assign t_below_hh = t_now < (to_fix(upper_q) - to_fix(hyst_q));
  assign t_above_lh = t_now > (to_fix(lower_q) + to_fix(hyst_q));
  assign t_below_ch = t_now < (to_fix(crit_q) - to_fix(hyst_q));

  // value in bits 15..3, flags below
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_q  <= 13'h0000;
      flags_q <= 3'h0;
    end else if (tick) begin
      temp_q             <= conv_result;
      flags_q[FLAG_OVER] <= t_over;
      flags_q[FLAG_HIGH] <= t_hi;
      flags_q[FLAG_LOW]  <= t_lo;
    end
  end

  // Frozen while selected so a read never sees a torn word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_word_sh_q <= 16'h0000;
    end else if (sel_s2_q) begin
      temp_word_sh_q <= {temp_q, flags_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warning output

  // four in a row with the queue on, else one
  assign qneed = queue_on ? QW'(QUEUE_LEN) : QW'(1);

  always_comb begin
    alert_state_t target;
    logic         fault;
    al_d   = al_q;
    aq_d   = aq_q;
    target = AL_IDLE;
    fault  = 1'b0;
    // read clears in interrupt mode; comparator mode ignores it
    if (temp_read && int_mode) begin
      case (al_q)
        AL_HI:   al_d = AL_WAIT_HI;
        AL_LO:   al_d = AL_WAIT_LO;
        AL_RE:   al_d = AL_IDLE;
        default: al_d = al_q;
      endcase
    end
    // Evaluated after the clear so a fault in the same cycle still sets
    if (tick) begin
      case (al_d)
        AL_IDLE: begin
          fault  = t_hi | t_lo;
          target = t_hi ? AL_HI : AL_LO;
        end
        // high fault re-arms below high minus hysteresis
        AL_WAIT_HI: begin
          fault  = t_below_hh;
          target = AL_RE;
        end
        // low fault re-arms above low plus hysteresis
        AL_WAIT_LO: begin
          fault  = t_above_lh;
          target = AL_RE;
        end
        AL_HI: begin
          if (!int_mode && t_below_hh) begin
            al_d = AL_IDLE;
          end
        end
        AL_LO: begin
          if (!int_mode && t_above_lh) begin
            al_d = AL_IDLE;
          end
        end
        default: ;
      endcase
      // a clean conversion empties the queue
      if (!fault) begin
        aq_d = '0;
      end else if (aq_q + 1'b1 >= qneed) begin
        al_d = target;
        aq_d = '0;
      end else begin
        aq_d = aq_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      al_q <= AL_IDLE;
      aq_q <= '0;
    end else if (wr_frame && cmd_q == CMD_WR_CFG && wdata_q[CFG_INT_MODE] != int_mode) begin
      // Mode change starts the warning logic afresh
      al_q <= AL_IDLE;
      aq_q <= '0;
    end else begin
      al_q <= al_d;
      aq_q <= aq_d;
    end
  end

  assign alert_act = (al_q == AL_HI) || (al_q == AL_LO) || (al_q == AL_RE);

  ////////////////////////////////////////////////////////////////////////////
  // Overheat output

  // comparator only; no read path reaches it; queued set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_q <= 1'b0;
      oq_q <= '0;
    end else if (tick) begin
      if (ot_q) begin
        if (t_below_ch) begin
          ot_q <= 1'b0;
        end
      end else if (!t_over) begin
        oq_q <= '0;
      end else if (oq_q + 1'b1 >= qneed) begin
        ot_q <= 1'b1;
        oq_q <= '0;
      end else begin
        oq_q <= oq_q + 1'b1;
      end
    end
  end

  // Open drain: pulls low when active with its polarity bit clear, or when idle with it set
  // polarity bits
  assign alert_o         = 1'b0;
  assign alert_oe        = alert_act ^ cfg_q[CFG_ALERT_POL];
  assign overheat_out_o  = 1'b0;
  assign overheat_out_oe = ot_q ^ cfg_q[CFG_OVERHEAT_POL];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  frame_len_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    commit && !tick && (link_cnt_q != FRAME_LEN_C || seen_tog_q == seen_ack_q)
    |=> $stable(cfg_q) && $stable(upper_q) && $stable(al_q)
  ) else $error("short or long frame changed state");

  cfg_mask_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_frame && cmd_q == CMD_WR_CFG |=> cfg_q == ($past(wdata_q) & CFG_WRITE_MASK)
  ) else $error("config write not masked");

  read_drive_a: assert property (
    @(posedge link_clk) disable iff (frame_idle)
    link_cnt_q == CMD_DONE_C && !fresh_q && is_read_cmd(cmd_q) |=> serial_data_io_oe [*8]
  ) else $error("read data not driven");

  int_clear_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    temp_read && int_mode && !tick && !$past(wr_frame) |=> !alert_act
  ) else $error("warning not cleared by read");

  cmp_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    frame_ok && !int_mode && !tick && !wr_frame |=> $stable(alert_act)
  ) else $error("read changed comparator warning");

  ot_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !tick |=> $stable(ot_q)
  ) else $error("overheat changed without conversion");

  ot_set_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    tick && !queue_on && !ot_q && t_over |=> ot_q
  ) else $error("overheat not set above limit");

  conv_only_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !tick |=> $stable(temp_q) && $stable(flags_q)
  ) else $error("temperature changed without conversion");

  shut_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    shutdown |-> !tick ##1 $stable(temp_q) && $stable(ot_q)
  ) else $error("shutdown did not freeze conversion");

  queue_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    queue_on && !ot_q && tick && oq_q == '0 |=> !ot_q
  ) else $error("overheat set before queue filled");

endmodule // temp_sensor_alarm_serial

/* File: core/temp_alarm_pkg.sv */
package temp_alarm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame
  localparam logic [4:0] CMD_DONE_C    = 5'h08;
  localparam logic [4:0] FRAME_LEN_C   = 5'h18;
  localparam logic [4:0] CNT_SAT_C     = 5'h1F;
  localparam int         CMD_START_BIT = 7;
  localparam int         CMD_DIR_BIT   = 6;

  // Command codes
  localparam logic [7:0] CMD_RD_TEMP  = 8'hC1;
  localparam logic [7:0] CMD_RD_CFG   = 8'hC3;
  localparam logic [7:0] CMD_WR_CFG   = 8'h83;
  localparam logic [7:0] CMD_RD_HYST  = 8'hC5;
  localparam logic [7:0] CMD_WR_HYST  = 8'h85;
  localparam logic [7:0] CMD_RD_CRIT  = 8'hC7;
  localparam logic [7:0] CMD_WR_CRIT  = 8'h87;
  localparam logic [7:0] CMD_RD_LOWER = 8'hC9;
  localparam logic [7:0] CMD_WR_LOWER = 8'h89;
  localparam logic [7:0] CMD_RD_UPPER = 8'hCB;
  localparam logic [7:0] CMD_WR_UPPER = 8'h8B;

  ////////////////////////////////////////////////////////////////////////////
  // control_settings fields
  localparam int          CFG_QUEUE_BIT    = 12;
  localparam int          CFG_ALERT_POL    = 11;
  localparam int          CFG_OVERHEAT_POL = 10;
  localparam int          CFG_INT_MODE     = 9;
  localparam int          CFG_SHUTDOWN     = 8;
  localparam logic [15:0] CFG_WRITE_MASK   = 16'h1F00;
  localparam logic [15:0] CFG_RESET        = 16'h0000;

  // Limit registers: 9 upper bits used
  localparam logic [15:0] LIMIT_MASK  = 16'hFF80;
  localparam logic [15:0] HYST_RESET  = 16'h0100;
  localparam logic [15:0] CRIT_RESET  = 16'h2800;
  localparam logic [15:0] LOWER_RESET = 16'h0500;
  localparam logic [15:0] UPPER_RESET = 16'h2000;

  // Temperature word flags
  localparam int FLAG_OVER = 2;
  localparam int FLAG_HIGH = 1;
  localparam int FLAG_LOW  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int CONV_PERIOD_MS  = 500;
  localparam int CONV_CYCLES_DEF = CLK_HZ / 1000 * CONV_PERIOD_MS;
  localparam int QUEUE_DEPTH     = 4;

  typedef enum logic [2:0] {
    AL_IDLE, AL_HI, AL_LO, AL_WAIT_HI, AL_WAIT_LO, AL_RE
  } alert_state_t;

endpackage

/* File: verif/serial_master_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module serial_master_model (
  output logic      link_clk,
  output logic      sel_n,
  output logic      data_line,
  input  wire logic dev_o,
  input  wire logic dev_oe
);
  logic m_en;
  logic m_bit;
  logic oe_early;
  logic oe_late;

  // Released line shows the inverse, never a conveniently held level
  assign data_line = dev_oe ? dev_o : (m_en ? m_bit : ~m_bit);

  initial begin
    link_clk = 1'b0;
    sel_n    = 1'b1;
    m_en     = 1'b0;
    m_bit    = 1'b0;
    oe_early = 1'b0;
    oe_late  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // master owns select and clock
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input int n_clk,
                      output logic [15:0] rdata);
    logic [23:0] word;
    word  = {cmd, wdata};
    rdata = 16'h0000;
    sel_n = 1'b0;
    m_en  = 1'b1;
    #20;
    for (int i = 0; i < n_clk; i++) begin
      // bit set before rise, MSB first
      if (i < 8 || (!cmd[6] && i < 24)) begin
        m_bit = word[23-i];
      end else if (cmd[6]) begin
        m_en = 1'b0;
      end
      #80 link_clk = 1'b1;
      // device bits taken at rising edge
      if (i == 7) begin
        oe_early = dev_oe;
      end
      if (i == 8) begin
        oe_late = dev_oe;
      end
      if (i >= 8 && cmd[6]) begin
        rdata = {rdata[14:0], data_line};
      end
      #80 link_clk = 1'b0;
    end
    #80;
    sel_n = 1'b1;
    m_en  = 1'b0;
    // Select high long enough for the commit
    #400;
  endtask

  // clock and data wiggle while deselected
  task automatic stray_clocks();
    m_en = 1'b1;
    for (int i = 0; i < 24; i++) begin
      m_bit = ~m_bit;
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    m_en = 1'b0;
    #400;
  endtask
endmodule // serial_master_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb;
  import temp_alarm_pkg::*;
  // Short conversion period keeps the run small
  localparam int CONV_C = 200;
  logic        ref_clk;
  logic        reset_n;
  logic        link_clk;
  logic        sel_n;
  logic        data_in;
  logic        data_out;
  logic        data_oe;
  logic [12:0] conv_result;
  logic        alert_o;
  logic        alert_oe;
  logic        overheat_o;
  logic        overheat_oe;
  logic [15:0] rd;
  int          n_fail;
  int          num_checks;

  temp_sensor_alarm_serial #(
    .CONV_CYCLES (CONV_C),
    .QUEUE_LEN   (QUEUE_DEPTH)
  ) temp_sensor_alarm_serial_i (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .link_clk          (link_clk),
    .sel_n             (sel_n),
    .serial_data_io_i  (data_in),
    .serial_data_io_o  (data_out),
    .serial_data_io_oe (data_oe),
    .conv_result       (conv_result),
    .alert_o           (alert_o),
    .alert_oe          (alert_oe),
    .overheat_out_o    (overheat_o),
    .overheat_out_oe   (overheat_oe)
  );

  serial_master_model serial_master_model_i (
    .link_clk  (link_clk),
    .sel_n     (sel_n),
    .data_line (data_in),
    .dev_o     (data_out),
    .dev_oe    (data_oe)
  );

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pins: {alert_oe, overheat_oe}
  task automatic pins(input logic [1:0] e);
    chk({12'h000, alert_o, overheat_o, alert_oe, overheat_oe}, {14'h0000, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_temp(input logic [12:0] v, input int n);
    conv_result = v;
    tick(n);
  endtask

  task automatic rd_reg(input logic [7:0] cmd, input logic [15:0] exp);
    serial_master_model_i.xfer(cmd, 16'h0000, 24, rd);
    chk(rd, exp);
  endtask

  task automatic wr_reg(input logic [7:0] cmd, input logic [15:0] val);
    serial_master_model_i.xfer(cmd, val, 24, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    pins(2'b00);
    rd_reg(CMD_RD_TEMP, 16'h0000);
    chk({14'h0000, serial_master_model_i.oe_early, serial_master_model_i.oe_late}, 16'h0001);
    chk({15'h0000, data_oe}, 16'h0000);
    rd_reg(CMD_RD_CFG, CFG_RESET);
    rd_reg(CMD_RD_HYST, HYST_RESET);
    rd_reg(CMD_RD_CRIT, CRIT_RESET);
    rd_reg(CMD_RD_LOWER, LOWER_RESET);
    rd_reg(CMD_RD_UPPER, UPPER_RESET);
  endtask

  task automatic t_regs();
    logic [7:0]  wc[4];
    logic [15:0] wv[4];
    logic [15:0] rv[4];
    wc = '{CMD_WR_HYST, CMD_WR_CRIT, CMD_WR_LOWER, CMD_WR_UPPER};
    wv = '{16'h03FF, 16'h3C7F, 16'h04FF, 16'h2AFF};
    rv = '{HYST_RESET, CRIT_RESET, LOWER_RESET, UPPER_RESET};
    wr_reg(CMD_WR_CFG, 16'hE0FF);
    rd_reg(CMD_RD_CFG, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(wc[i], wv[i]);
      rd_reg(wc[i] | 8'h40, wv[i] & 16'hFF80);
      wr_reg(wc[i], rv[i]);
      rd_reg(wc[i] | 8'h40, rv[i]);
    end
  endtask

  task automatic t_bad_frames();
    serial_master_model_i.xfer(CMD_WR_CFG, 16'h0200, 23, rd);
    serial_master_model_i.xfer(CMD_WR_CFG, 16'h0200, 25, rd);
    serial_master_model_i.xfer(8'h03, 16'h0200, 24, rd);
    serial_master_model_i.stray_clocks();
    rd_reg(CMD_RD_CFG, 16'h0000);
  endtask

  task automatic t_comparator();
    set_temp(13'h0410, 450);
    pins(2'b10);
    rd_reg(CMD_RD_TEMP, 16'h2082);
    pins(2'b10);
    set_temp(13'h03F0, 450);
    pins(2'b10);
    set_temp(13'h03D0, 450);
    pins(2'b00);
    set_temp(13'h0090, 450);
    pins(2'b10);
    rd_reg(CMD_RD_TEMP, 16'h0481);
    set_temp(13'h00B0, 450);
    pins(2'b10);
    set_temp(13'h0300, 450);
    pins(2'b00);
  endtask

  task automatic t_overheat();
    set_temp(13'h0510, 450);
    pins(2'b11);
    rd_reg(CMD_RD_TEMP, 16'h2886);
    pins(2'b11);
    set_temp(13'h04F0, 450);
    pins(2'b11);
    set_temp(13'h04D0, 450);
    pins(2'b10);
    wr_reg(CMD_WR_CFG, 16'h0C00);
    pins(2'b01);
    wr_reg(CMD_WR_CFG, 16'h0000);
    set_temp(13'h0300, 450);
    pins(2'b00);
  endtask

  task automatic t_interrupt();
    wr_reg(CMD_WR_CFG, 16'h0200);
    set_temp(13'h0410, 450);
    pins(2'b10);
    set_temp(13'h0300, 450);
    pins(2'b10);
    set_temp(13'h0410, 450);
    rd_reg(CMD_RD_TEMP, 16'h2082);
    pins(2'b00);
    tick(450);
    pins(2'b00);
    set_temp(13'h0300, 450);
    pins(2'b10);
    serial_master_model_i.xfer(CMD_RD_TEMP, 16'h0000, 0, rd);
    pins(2'b10);
    rd_reg(CMD_RD_TEMP, 16'h1800);
    pins(2'b00);
    set_temp(13'h0090, 450);
    pins(2'b10);
    rd_reg(CMD_RD_TEMP, 16'h0481);
    pins(2'b00);
    set_temp(13'h00B0, 450);
    pins(2'b00);
    set_temp(13'h00D0, 450);
    pins(2'b10);
    wr_reg(CMD_WR_CFG, 16'h0000);
    pins(2'b00);
  endtask

  task automatic t_queue();
    wr_reg(CMD_WR_CFG, 16'h1000);
    set_temp(13'h0410, 500);
    pins(2'b00);
    set_temp(13'h0300, 250);
    set_temp(13'h0410, 500);
    pins(2'b00);
    tick(400);
    pins(2'b10);
    wr_reg(CMD_WR_CFG, 16'h0000);
    set_temp(13'h0300, 450);
    pins(2'b00);
  endtask

  task automatic t_shutdown();
    wr_reg(CMD_WR_CFG, 16'h0100);
    set_temp(13'h0200, 450);
    rd_reg(CMD_RD_TEMP, 16'h1800);
    rd_reg(CMD_RD_CFG, 16'h0100);
    wr_reg(CMD_WR_CFG, 16'h0000);
    set_temp(13'h0200, 450);
    rd_reg(CMD_RD_TEMP, 16'h1000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail      = 0;
    num_checks  = 0;
    conv_result = 13'h0300;
    reset_n     = 1'b0;
    tick(3);
    reset_n = 1'b1;
    tick(3);
    t_reset();
    t_regs();
    t_bad_frames();
    t_comparator();
    t_overheat();
    t_interrupt();
    t_queue();
    t_shutdown();
    end_of_test();
  end

  // Hang guard
  initial begin
    #900_000;
    n_fail++;
    end_of_test();
  end
endmodule // tb
